// File: rdc_seq_pkg.sv
// Purpose: Shared constants and types for the reset and power sequencer
// Assumes: 40 MHz system clock, 16-bit serial register frames
// Notes: Register addresses below are local choices of this design
package rdc_seq_pkg;

    // Serial frame layout
    localparam int FRAME_BITS = 16;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam logic RW_READ = 1'b1; // Frame bit 15 set means read

    // Register addresses
    localparam logic [6:0] ADDR_SOFT_RESET = 7'h70;
    localparam logic [6:0] ADDR_POWER_SAVE = 7'h71;
    localparam logic [6:0] ADDR_STATUS = 7'h72;

    // Field positions and reset values
    localparam int SOFT_RESET_BIT = 0;
    localparam int POWER_SAVE_BIT = 0;
    localparam logic [7:0] SOFT_RESET_RST = 8'h00;
    localparam logic [7:0] POWER_SAVE_RST = 8'h01;

    // Timing
    localparam longint CLK_HZ = 40000000;
    localparam longint PSAVE_WAIT_MS = 30;
    localparam int PSAVE_WAIT_CYCLES = int'(CLK_HZ * PSAVE_WAIT_MS / 1000);

    // Angle path widths
    localparam int ANGLE_W = 12;
    localparam int PHASE_W = 16;

    // One register write taken from a complete frame
    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] data;
    } reg_write_t;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_PSAVE = 2'b01,
        ST_SETTLE = 2'b10,
        ST_READY = 2'b11
    } seq_state_t;

endpackage

// File: spi_frame_slave.sv
// Purpose: Serial slave taking 16-bit register frames, MSB first
// Assumes: Clock idles low, data sampled on rising and driven on falling
// Notes: Frames of any other length are dropped at chip-select release
`timescale 1ns/100ps
module spi_frame_slave
    import rdc_seq_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sclk_i,
    input wire logic sdi_i,
    input wire logic cs_n_i,
    input wire logic [7:0] rd_data_i,
    output logic sdo_o,
    output logic [6:0] addr_o,
    output logic wr_valid_o,
    output reg_write_t wr_o
);

    logic [2:0] sync1_reg; // First stage, read only by second stage
    logic [2:0] sync2_reg; // {sclk, sdi, cs_n} safe to use
    logic sclk_prev_reg; // For edge detection
    logic cs_prev_reg; // For release detection
    logic [4:0] cnt_reg; // Bits taken in this frame
    logic [15:0] shift_reg; // Incoming frame
    logic [7:0] out_reg; // Outgoing read data

    logic sclk_s, sdi_s, cs_n_s, rise, fall;
    assign sclk_s = sync2_reg[2];
    assign sdi_s = sync2_reg[1];
    assign cs_n_s = sync2_reg[0];
    assign rise = sclk_s & ~sclk_prev_reg;
    assign fall = ~sclk_s & sclk_prev_reg;
    // Address bits once the first byte is in
    assign addr_o = shift_reg[6:0];

    // Two-stage pin synchroniser
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync1_reg <= 3'h1;
            sync2_reg <= 3'h1;
            sclk_prev_reg <= 1'b0;
            cs_prev_reg <= 1'b1;
        end else begin
            sync1_reg <= {sclk_i, sdi_i, cs_n_i};
            sync2_reg <= sync1_reg;
            sclk_prev_reg <= sclk_s;
            cs_prev_reg <= cs_n_s;
        end
    end

    // Shift in on rising edges while selected
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || cs_n_s) begin
            cnt_reg <= 5'h00;
            shift_reg <= 16'h0000;
        end else if (rise) begin
            shift_reg <= {shift_reg[14:0], sdi_s};
            // Saturate so overlong frames stay invalid
            if (cnt_reg != 5'h11) begin
                cnt_reg <= cnt_reg + 5'h01;
            end
        end
    end

    // Drive read data on falling edges after the address byte
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || cs_n_s) begin
            sdo_o <= 1'b0;
            out_reg <= 8'h00;
        end else if (fall && cnt_reg == 5'h08 && shift_reg[7] == RW_READ) begin
            sdo_o <= rd_data_i[7];
            out_reg <= {rd_data_i[6:0], 1'b0};
        end else if (fall && cnt_reg > 5'h08) begin
            sdo_o <= out_reg[7];
            out_reg <= {out_reg[6:0], 1'b0};
        end
    end

    // Commit a write only for an exact 16-bit frame
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_valid_o <= 1'b0;
            wr_o <= '0;
        end else begin
            wr_valid_o <= cs_n_s && !cs_prev_reg && cnt_reg == 5'h10 &&
                          shift_reg[15] != RW_READ;
            wr_o <= '{addr: shift_reg[14:8], data: shift_reg[7:0]};
        end
    end

endmodule

// File: resolver_reset_power_sequencer.sv
// Purpose: Reset sources, power-saving release and angle wave output
// Assumes: Pins are asynchronous to clk_i; angle_i is on clk_i
// Notes: Angle wave lag is angle_i/2^ANGLE_W of the excitation period
`timescale 1ns/100ps
module resolver_reset_power_sequencer
    import rdc_seq_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = PSAVE_WAIT_CYCLES,
    parameter int AW = ANGLE_W,
    parameter int PW = PHASE_W
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic reset_pin_n_i,
    input wire logic supply_low_i,
    input wire logic excite_i,
    input wire logic [AW-1:0] angle_i,
    input wire logic sclk_i,
    input wire logic sdi_i,
    input wire logic cs_n_i,
    output logic sdo_o,
    output logic angle_out_o,
    output logic power_save_o,
    output logic in_reset_o,
    output logic conv_ready_o
);

    logic [2:0] pin_sync1_reg; // First stage, read only by second
    logic [2:0] pin_sync2_reg; // {reset_n, supply_low, excite}
    logic excite_prev_reg; // Excitation edge detection
    logic [7:0] soft_reset_reg; // Software reset register
    logic [7:0] power_save_reg; // Power-saving control register
    seq_state_t state_reg, state_next;
    logic [31:0] settle_reg; // Settling countdown
    logic [PW-1:0] phase_reg; // Cycles since excitation rise
    logic [PW-1:0] period_reg; // Last measured excitation period

    logic hw_reset, any_reset, wr_valid, excite_rise;
    logic [6:0] spi_addr;
    logic [7:0] rd_data;
    reg_write_t wr;
    logic [AW+PW-1:0] lag_full;
    logic [PW-1:0] lag, shifted;

    // Serial register port
    spi_frame_slave u_spi (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .sclk_i(sclk_i),
        .sdi_i(sdi_i),
        .cs_n_i(cs_n_i),
        .rd_data_i(rd_data),
        .sdo_o(sdo_o),
        .addr_o(spi_addr),
        .wr_valid_o(wr_valid),
        .wr_o(wr)
    );

    // Pin synchroniser for reset, supply detector and excitation
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pin_sync1_reg <= 3'h4;
            pin_sync2_reg <= 3'h4;
            excite_prev_reg <= 1'b0;
        end else begin
            pin_sync1_reg <= {reset_pin_n_i, supply_low_i, excite_i};
            pin_sync2_reg <= pin_sync1_reg;
            excite_prev_reg <= pin_sync2_reg[0];
        end
    end

    // Hardware reset: pin low, or supply at or below threshold
    assign hw_reset = !rst_n_i || !pin_sync2_reg[2]
                      || pin_sync2_reg[1];
    // Software reset bit keeps the device in reset while set
    assign any_reset = hw_reset || soft_reset_reg[SOFT_RESET_BIT];
    assign excite_rise = pin_sync2_reg[0] && !excite_prev_reg;

    // Software reset register, cleared by hardware reset or by writing 0
    always_ff @(posedge clk_i) begin
        if (hw_reset) begin
            soft_reset_reg <= SOFT_RESET_RST;
        end else if (wr_valid && wr.addr == ADDR_SOFT_RESET) begin
            // Write 1 enters, write 0 leaves the reset
            soft_reset_reg <= {7'h00, wr.data[SOFT_RESET_BIT]};
        end
    end

    // Power-saving register, set again by every reset source
    always_ff @(posedge clk_i) begin
        if (any_reset) begin
            power_save_reg <= POWER_SAVE_RST;
        end else if (wr_valid && wr.addr == ADDR_POWER_SAVE) begin
            power_save_reg <= {7'h00, wr.data[POWER_SAVE_BIT]};
        end
    end

    // Read-back mux, unmapped addresses read zero
    always_comb begin
        case (spi_addr)
            ADDR_SOFT_RESET: rd_data = soft_reset_reg;
            ADDR_POWER_SAVE: rd_data = power_save_reg;
            ADDR_STATUS: rd_data = {6'h00, state_reg};
            default: rd_data = 8'h00;
        endcase
    end

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RESET: begin
                // Leaving reset always lands in power saving
                if (!any_reset) begin
                    state_next = ST_PSAVE;
                end
            end
            ST_PSAVE: begin
                if (!power_save_reg[POWER_SAVE_BIT]) begin
                    state_next = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (power_save_reg[POWER_SAVE_BIT]) begin
                    state_next = ST_PSAVE;
                end else if (settle_reg == 32'h0) begin
                    state_next = ST_READY;
                end
            end
            ST_READY: begin
                if (power_save_reg[POWER_SAVE_BIT]) begin
                    state_next = ST_PSAVE;
                end
            end
            default: state_next = ST_RESET;
        endcase
        // Any reset source wins over everything
        if (any_reset) begin
            state_next = ST_RESET;
        end
    end

    // Sequencer state register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Settling wait after leaving power saving
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            settle_reg <= 32'h0;
        end else if (state_next == ST_SETTLE && state_reg != ST_SETTLE) begin
            settle_reg <= SETTLE_CYCLES - 32'h1;
        end else if (state_reg == ST_SETTLE && settle_reg != 32'h0) begin
            settle_reg <= settle_reg - 32'h1;
        end
    end

    // Status outputs
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            in_reset_o <= 1'b1;
            power_save_o <= 1'b1;
            conv_ready_o <= 1'b0;
        end else begin
            in_reset_o <= state_next == ST_RESET;
            power_save_o <= state_next == ST_RESET ||
                            state_next == ST_PSAVE;
            conv_ready_o <= state_next == ST_READY;
        end
    end

    // Excitation period measurement, rising edge to rising edge
    always_ff @(posedge clk_i) begin
        if (any_reset) begin
            phase_reg <= '0;
            period_reg <= '0;
        end else if (excite_rise) begin
            phase_reg <= '0;
            period_reg <= phase_reg + PW'(1);
        end else if (phase_reg != '1) begin
            phase_reg <= phase_reg + PW'(1);
        end
    end

    // Lag in cycles, proportional to the angle
    assign lag_full = angle_i * period_reg;
    assign lag = lag_full[AW +: PW];
    // Phase relative to the lagged edge, wrapped into one period
    assign shifted = (phase_reg >= lag) ? phase_reg - lag
                                        : phase_reg + period_reg - lag;

    // Angle wave: high for the first half period after the lagged edge
    always_ff @(posedge clk_i) begin
        if (any_reset) begin
            angle_out_o <= 1'b0;
        end else if (state_reg == ST_SETTLE || state_reg == ST_READY) begin
            angle_out_o <= shifted < (period_reg >> 1);
        end else begin
            angle_out_o <= 1'b0;
        end
    end

endmodule

// File: seq_chk.sv
// Purpose: Assertions on reset and power-saving outputs
// Assumes: One clock domain, synchronous active-low reset
// Notes: Bound to the sequencer top, sees only its ports
`timescale 1ns/100ps
module seq_chk #(
    parameter int unsigned SETTLE_CYCLES = 20
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic reset_pin_n_i,
    input wire logic supply_low_i,
    input wire logic angle_out_o,
    input wire logic power_save_o,
    input wire logic in_reset_o,
    input wire logic conv_ready_o
);
    int unsigned set_cnt; // Cycles spent settling so far
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Count cycles out of power saving before ready
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || power_save_o) begin
            set_cnt <= 0;
        end else if (!conv_ready_o) begin
            set_cnt <= set_cnt + 1;
        end
    end
    sequence pin_held;
        !reset_pin_n_i [*5];
    endsequence
    sequence reset_left;
        $fell(in_reset_o);
    endsequence
    pin_reset_a: assert property (pin_held |->
        in_reset_o && power_save_o)
        else $error("pin reset not seen");
    supply_reset_a: assert property (supply_low_i [*5] |-> in_reset_o)
        else $error("supply drop not reset");
    supply_hold_a: assert property (supply_low_i && in_reset_o |=>
        in_reset_o)
        else $error("reset left during supply drop");
    leave_psave_a: assert property (reset_left |->
        power_save_o [*2])
        else $error("reset left without power saving");
    reset_psave_a: assert property (in_reset_o |-> power_save_o)
        else $error("reset without power saving");
    angle_quiet_a: assert property (in_reset_o |-> !angle_out_o)
        else $error("angle wave active in reset");
    ready_clear_a: assert property (conv_ready_o |-> !power_save_o)
        else $error("ready while power saving");
    settle_len_a: assert property ($rose(conv_ready_o) |->
        set_cnt inside {[SETTLE_CYCLES-2:SETTLE_CYCLES+2]})
        else $error("settle wait wrong length");
endmodule
bind resolver_reset_power_sequencer seq_chk #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .reset_pin_n_i(reset_pin_n_i),
    .supply_low_i(supply_low_i), .angle_out_o(angle_out_o),
    .power_save_o(power_save_o), .in_reset_o(in_reset_o),
    .conv_ready_o(conv_ready_o));

// File: host_model.sv
// Purpose: Host model, serial master and excitation source
// Assumes: Serial half period of 5 clk, excitation period 64 clk
// Notes: Data line is inverted once deselected, never left at last bit
`timescale 1ns/100ps
module host_model (
    input wire logic clk_i,
    input wire logic sdo_i,
    output logic sclk_o,
    output logic sdi_o,
    output logic cs_n_o,
    output logic excite_o
);
    localparam logic RW_READ_BIT = 1'b1; // Read flag as the design takes it
    logic [7:0] rd_byte; // Bits taken from sdo
    event rd_done; // Read byte complete
    initial begin
        sclk_o = 0;
        sdi_o = 0;
        cs_n_o = 1;
        excite_o = 0;
    end
    // Rectangular excitation reference
    always begin
        repeat (32) @(posedge clk_i);
        #1 excite_o = ~excite_o;
    end
    // Wait n edges, then step just past the edge
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Frame of nbits, MSB first, sdo taken on rises 9 to 16
    task automatic xfer(input logic [15:0] w, input int nbits);
        int i;
        wait_clk(1);
        cs_n_o = 0;
        for (i = 15; i > 15 - nbits; i--) begin
            sdi_o = w[i];
            wait_clk(5);
            sclk_o = 1;
            if (i < 8) rd_byte[i] = sdo_i;
            wait_clk(5);
            sclk_o = 0;
        end
        wait_clk(2);
        cs_n_o = 1;
        sdi_o = ~sdi_o;
        wait_clk(4);
        if (w[15] == RW_READ_BIT) -> rd_done;
    endtask
endmodule

// File: tb_top.sv
// Purpose: Self-checking bench for the reset and power sequencer
// Assumes: Host model drives serial and excitation pins
// Notes: Settle wait shortened to 20 cycles
`timescale 1ns/100ps
module tb_top;
    import rdc_seq_pkg::*;
    localparam int unsigned SETTLE = 20; // Short settle for simulation
    logic clk_i = 0, rst_n_i = 0, reset_pin_n_i = 1, supply_low_i = 0;
    logic [11:0] angle_i = 12'h800; // Angle from analog path
    logic sclk_i, sdi_i, cs_n_i, excite_i, sdo_o, angle_out_o;
    logic power_save_o, in_reset_o, conv_ready_o;
    int error_cnt = 0, check_count = 0, cyc = 0, k;
    longint exc_t; // Last excitation rise in ns
    logic [2:0] st_q[$]; // Expected reset, psave, ready
    logic [7:0] rd_q[$]; // Expected read bytes
    int lag_q[$]; // Expected angle lag in cycles
    event st_ev; // Status sample request
    always #12.5 clk_i = ~clk_i;
    resolver_reset_power_sequencer #(.SETTLE_CYCLES(SETTLE)) DUT (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .reset_pin_n_i(reset_pin_n_i),
        .supply_low_i(supply_low_i), .excite_i(excite_i),
        .angle_i(angle_i), .sclk_i(sclk_i), .sdi_i(sdi_i),
        .cs_n_i(cs_n_i), .sdo_o(sdo_o), .angle_out_o(angle_out_o),
        .power_save_o(power_save_o), .in_reset_o(in_reset_o),
        .conv_ready_o(conv_ready_o));
    host_model u_host (.clk_i(clk_i), .sdo_i(sdo_o), .sclk_o(sclk_i),
        .sdi_o(sdi_i), .cs_n_o(cs_n_i), .excite_o(excite_i));
    task automatic cmp_exact(input string nm, input logic [7:0] e,
        input logic [7:0] s);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic cmp_lag(input int e, input int s);
        check_count++;
        if (s < e || s > e + 7) begin
            error_cnt++;
            $display("BAD lag exp %0d got %0d", e, s);
        end
    endtask
    // Watchers take the oldest note as each result appears
    always @(st_ev) cmp_exact("status", {5'h0, st_q.pop_front()},
        {5'h0, in_reset_o, power_save_o, conv_ready_o});
    always @(u_host.rd_done) cmp_exact("rdata", rd_q.pop_front(),
        u_host.rd_byte);
    always @(posedge excite_i) exc_t = $time;
    always @(posedge angle_out_o) begin
        if (lag_q.size() > 0) cmp_lag(lag_q.pop_front(),
            int'(($time - exc_t) / 25));
    end
    task automatic expect_st(input logic [2:0] e, input int n);
        u_host.wait_clk(n);
        st_q.push_back(e);
        -> st_ev;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_host.xfer({~RW_READ, a, d}, 16);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        u_host.xfer({RW_READ, a, 8'h00}, 16);
    endtask
    task automatic wait_ready();
        int i;
        for (i = 0; i < SETTLE + 50 && conv_ready_o !== 1'b1; i++)
            u_host.wait_clk(1);
        expect_st(3'b001, 1);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Cycle ceiling against hangs
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc >= 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(32'h8d05));
        expect_st(3'b110, 3);
        u_host.wait_clk(1);
        rst_n_i = 1;
        expect_st(3'b010, 6);
        rd(ADDR_POWER_SAVE, POWER_SAVE_RST);
        rd(ADDR_STATUS, 8'h01);
        rd(7'h10, 8'h00);
        $display("test reset_release done");
        wr(ADDR_POWER_SAVE, 8'h00);
        expect_st(3'b000, 4);
        wait_ready();
        for (k = 0; k < 3; k++) begin
            angle_i = 12'(512 + $urandom % 3072);
            u_host.wait_clk(256);
            lag_q.push_back(int'(angle_i >> 6));
            u_host.wait_clk(70);
        end
        // Every noted lag must have met a rising angle edge
        cmp_exact("lag_left", 8'h00, 8'(lag_q.size()));
        $display("test angle_wave done");
        wr(ADDR_SOFT_RESET, 8'h01);
        expect_st(3'b110, 6);
        rd(ADDR_SOFT_RESET, 8'h01);
        wr(ADDR_SOFT_RESET, 8'h00);
        expect_st(3'b010, 8);
        u_host.xfer({~RW_READ, ADDR_POWER_SAVE, 8'h00}, 15);
        expect_st(3'b010, 8);
        $display("test soft_reset done");
        wr(ADDR_POWER_SAVE, 8'h00);
        expect_st(3'b000, 4);
        supply_low_i = 1;
        expect_st(3'b110, 8);
        expect_st(3'b110, 40);
        supply_low_i = 0;
        expect_st(3'b010, 8);
        rd(ADDR_POWER_SAVE, POWER_SAVE_RST);
        $display("test supply_drop done");
        wr(ADDR_POWER_SAVE, 8'h00);
        wait_ready();
        rd(ADDR_STATUS, 8'h03);
        // Re-entering power saving from ready, then leaving again
        wr(ADDR_POWER_SAVE, 8'h01);
        expect_st(3'b010, 4);
        wr(ADDR_POWER_SAVE, 8'h00);
        wait_ready();
        reset_pin_n_i = 0;
        expect_st(3'b110, 14);
        reset_pin_n_i = 1;
        expect_st(3'b010, 8);
        rd(ADDR_POWER_SAVE, POWER_SAVE_RST);
        $display("test pin_reset done");
        tally_and_finish();
    end
endmodule
